// *** include/sixio_pkg.sv ***
// Notes on behaviour
// - Six pins, five bidirectional; each has direction, slew, threshold bits, and all but pin 3 latch, analog, drain bits.
// - Direction 1 turns the driver off; 0 drives the output latch onto the pin.
// - Pin 3 is input only; its direction bit always reads 1.
// - Pin level register reads live pins; writing it updates the output latch.
// - Latch writes equal pin level writes; latch reads return stored latch bits.
// - Output latch holds the latest write to either register.
// - Port writes store the written bits into the latch; no bit comes from the pins read.
// - Analog select set disables the pin's digital input buffer.
// - An analog pin always reads 0 digitally.
// - Direction still controls the driver in analog mode; digital outputs still drive.
// - An enabled analog output forces the digital driver to high impedance.
// - After reset the latch is the output source of every pin but pin 3; others only via remap selection.
// - An enabled peripheral stops general purpose output but pin reads still work.
// - Open-drain bit set means sink only; clear means push-pull.
// - A pin under the I2C module is open-drain whatever its drain bit.
// - Slew bit set limits slew rate; clear gives full rate.
// - Threshold bit picks Schmitt CMOS or TTL for reads.
// - Analog select bits reset to analog mode.
// - Pull-up off on outputs unless open-drain; then on only while output high.
package sixio_pkg;
    localparam int PIN_W = 6;
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_PIN = 8'h00;
    localparam logic [7:0] OFS_LAT = 8'h04;
    localparam logic [7:0] OFS_DIR = 8'h08;
    localparam logic [7:0] OFS_ANA = 8'h0c;
    localparam logic [7:0] OFS_WPU = 8'h10;
    localparam logic [7:0] OFS_ODC = 8'h14;
    localparam logic [7:0] OFS_SLR = 8'h18;
    localparam logic [7:0] OFS_LVL = 8'h1c;
    localparam int IN_ONLY_BIT = 3;
    // Bits that exist in each register; the others read as constants.
    localparam logic [5:0] MASK_FULL = 6'h3f;
    localparam logic [5:0] MASK_NO3 = 6'h37;
    localparam logic [5:0] DIR_FIXED_ONES = 6'h08;
    localparam logic [5:0] RST_DIR = 6'h3f;
    localparam logic [5:0] RST_LAT = 6'h00;
    localparam logic [5:0] RST_ANA = 6'h37;
    localparam logic [5:0] RST_WPU = 6'h00;
    localparam logic [5:0] RST_ODC = 6'h00;
    localparam logic [5:0] RST_SLR = 6'h3f;
    localparam logic [5:0] RST_LVL = 6'h3f;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [3:0] {
        SIXIO_R_PIN = 4'h0,
        SIXIO_R_LAT = 4'h1,
        SIXIO_R_DIR = 4'h2,
        SIXIO_R_ANA = 4'h3,
        SIXIO_R_WPU = 4'h4,
        SIXIO_R_ODC = 4'h5,
        SIXIO_R_SLR = 4'h6,
        SIXIO_R_LVL = 4'h7,
        SIXIO_R_NONE = 4'hf
    } sixio_reg_t;
endpackage

// *** include/sixio_cfg_if.sv ***
`timescale 1ns/10ps
interface sixio_cfg_if;
    logic [sixio_pkg::PIN_W-1:0] dir;
    logic [sixio_pkg::PIN_W-1:0] lat;
    logic [sixio_pkg::PIN_W-1:0] ana;
    logic [sixio_pkg::PIN_W-1:0] wpu;
    logic [sixio_pkg::PIN_W-1:0] odc;
    logic [sixio_pkg::PIN_W-1:0] slr;
    logic [sixio_pkg::PIN_W-1:0] lvl;
    modport ctrl (output dir, output lat, output ana, output wpu, output odc, output slr,
        output lvl);
    modport pad (input dir, input lat, input ana, input wpu, input odc, input slr,
        input lvl);
endinterface

// *** logic/sixio_pad_mux.sv ***
`timescale 1ns/10ps
module sixio_pad_mux (
    sixio_cfg_if.pad cfg,
    input wire logic [sixio_pkg::PIN_W-1:0] periph_sel,
    input wire logic [sixio_pkg::PIN_W-1:0] periph_out,
    input wire logic [sixio_pkg::PIN_W-1:0] i2c_sel,
    input wire logic [sixio_pkg::PIN_W-1:0] aout_en,
    output logic [sixio_pkg::PIN_W-1:0] pin_o,
    output logic [sixio_pkg::PIN_W-1:0] pin_oe_n,
    output logic [sixio_pkg::PIN_W-1:0] pull_up_en,
    output logic [sixio_pkg::PIN_W-1:0] slew_limit,
    output logic [sixio_pkg::PIN_W-1:0] thresh_cmos,
    output logic [sixio_pkg::PIN_W-1:0] in_buf_en
);
    logic [sixio_pkg::PIN_W-1:0] src;
    logic [sixio_pkg::PIN_W-1:0] od;
    logic [sixio_pkg::PIN_W-1:0] drive;
    logic [sixio_pkg::PIN_W-1:0] dir_eff;

    always_comb begin
        dir_eff = cfg.dir | sixio_pkg::DIR_FIXED_ONES;
        // The latch is the source unless remap hands the pin to a peripheral.
        src = (periph_sel & periph_out) | (~periph_sel & cfg.lat);
        od = cfg.odc | i2c_sel;
        // Analog mode does not touch the driver; only the direction bit and aout_en do.
        drive = ~dir_eff & ~aout_en;
        // An open-drain pin only pulls low; a high value leaves the pad floating.
        pin_oe_n = ~(drive & ~(od & src));
        pin_o = src & ~od;
        pull_up_en = cfg.wpu & (dir_eff | (od & src));
        slew_limit = cfg.slr;
        thresh_cmos = cfg.lvl;
        in_buf_en = ~cfg.ana;
    end
endmodule // sixio_pad_mux

// *** logic/sixio_port.sv ***
`timescale 1ns/10ps
module sixio_port (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [sixio_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [sixio_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [sixio_pkg::PIN_W-1:0] pin_i,
    output logic [sixio_pkg::PIN_W-1:0] pin_o,
    output logic [sixio_pkg::PIN_W-1:0] pin_oe_n,
    output logic [sixio_pkg::PIN_W-1:0] pull_up_en,
    output logic [sixio_pkg::PIN_W-1:0] slew_limit,
    output logic [sixio_pkg::PIN_W-1:0] thresh_cmos,
    output logic [sixio_pkg::PIN_W-1:0] in_buf_en,
    output logic [sixio_pkg::PIN_W-1:0] pin_level,
    input wire logic [sixio_pkg::PIN_W-1:0] periph_sel,
    input wire logic [sixio_pkg::PIN_W-1:0] periph_out,
    input wire logic [sixio_pkg::PIN_W-1:0] i2c_sel,
    input wire logic [sixio_pkg::PIN_W-1:0] aout_en
);
    localparam int W = sixio_pkg::PIN_W;

    logic [W-1:0] dir_r;
    logic [W-1:0] lat_r;
    logic [W-1:0] ana_r;
    logic [W-1:0] wpu_r;
    logic [W-1:0] odc_r;
    logic [W-1:0] slr_r;
    logic [W-1:0] lvl_r;
    logic [W-1:0] pin_meta_r;
    logic [W-1:0] pin_sync_r;
    logic [W-1:0] pin_read;
    logic [W-1:0] lat_nxt;
    logic aw_full_r;
    logic w_full_r;
    logic [sixio_pkg::ADDR_W-1:0] aw_addr_r;
    logic [7:0] w_byte_r;
    logic w_lane_r;
    logic wr_go;
    logic wr_hit_lat;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [1:0] rresp_r;
    logic [31:0] rdata_r;
    sixio_pkg::sixio_reg_t wr_sel;
    sixio_pkg::sixio_reg_t rd_sel;

    sixio_cfg_if cfg ();

    function automatic sixio_pkg::sixio_reg_t decode(input logic [sixio_pkg::ADDR_W-1:0] a);
        unique case (a)
            sixio_pkg::OFS_PIN: decode = sixio_pkg::SIXIO_R_PIN;
            sixio_pkg::OFS_LAT: decode = sixio_pkg::SIXIO_R_LAT;
            sixio_pkg::OFS_DIR: decode = sixio_pkg::SIXIO_R_DIR;
            sixio_pkg::OFS_ANA: decode = sixio_pkg::SIXIO_R_ANA;
            sixio_pkg::OFS_WPU: decode = sixio_pkg::SIXIO_R_WPU;
            sixio_pkg::OFS_ODC: decode = sixio_pkg::SIXIO_R_ODC;
            sixio_pkg::OFS_SLR: decode = sixio_pkg::SIXIO_R_SLR;
            sixio_pkg::OFS_LVL: decode = sixio_pkg::SIXIO_R_LVL;
            default: decode = sixio_pkg::SIXIO_R_NONE;
        endcase
    endfunction

    // Only the low byte lane carries register bits; bits that do not exist keep old.
    function automatic logic [W-1:0] merge(input logic [W-1:0] old, input logic [7:0] wb,
        input logic [W-1:0] mask);
        merge = (old & ~mask) | (wb[W-1:0] & mask);
    endfunction

    // Pins cross from the board, so two flops sit before any reader.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_meta_r <= '0;
            pin_sync_r <= '0;
        end else begin
            pin_meta_r <= pin_i;
            pin_sync_r <= pin_meta_r;
        end
    end

    // The threshold choice is applied in the pad, so the synced level already obeys it.
    assign pin_read = pin_sync_r & ~ana_r;
    assign pin_level = pin_read;

    // Write channel: address and data are taken in either order, then committed.
    assign s_axi_awready = !aw_full_r && !bvalid_r;
    assign s_axi_wready = !w_full_r && !bvalid_r;
    assign wr_go = aw_full_r && w_full_r && !bvalid_r;
    assign wr_sel = decode(aw_addr_r);
    assign wr_hit_lat = wr_go && w_lane_r &&
        (wr_sel == sixio_pkg::SIXIO_R_PIN || wr_sel == sixio_pkg::SIXIO_R_LAT);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_r <= 1'b0;
            aw_addr_r <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_full_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
        end else if (wr_go) begin
            aw_full_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full_r <= 1'b0;
            w_byte_r <= 8'h00;
            w_lane_r <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_full_r <= 1'b1;
            w_byte_r <= s_axi_wdata[7:0];
            w_lane_r <= s_axi_wstrb[0];
        end else if (wr_go) begin
            w_full_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r <= sixio_pkg::RESP_OKAY;
        end else if (wr_go) begin
            bvalid_r <= 1'b1;
            bresp_r <= (wr_sel == sixio_pkg::SIXIO_R_NONE) ?
                sixio_pkg::RESP_SLVERR : sixio_pkg::RESP_OKAY;
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;

    // A byte write stores the written bits; bit 3, which the latch lacks, is cleared, not taken from the pins read.
    assign lat_nxt = merge(pin_read, w_byte_r, sixio_pkg::MASK_NO3) &
        sixio_pkg::MASK_NO3;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lat_r <= sixio_pkg::RST_LAT;
        end else if (wr_hit_lat) begin
            lat_r <= lat_nxt;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dir_r <= sixio_pkg::RST_DIR;
        end else if (wr_go && w_lane_r && wr_sel == sixio_pkg::SIXIO_R_DIR) begin
            dir_r <= merge(dir_r, w_byte_r, sixio_pkg::MASK_NO3) |
                sixio_pkg::DIR_FIXED_ONES;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ana_r <= sixio_pkg::RST_ANA;
        end else if (wr_go && w_lane_r && wr_sel == sixio_pkg::SIXIO_R_ANA) begin
            ana_r <= merge(ana_r, w_byte_r, sixio_pkg::MASK_NO3);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wpu_r <= sixio_pkg::RST_WPU;
            odc_r <= sixio_pkg::RST_ODC;
            slr_r <= sixio_pkg::RST_SLR;
            lvl_r <= sixio_pkg::RST_LVL;
        end else if (wr_go && w_lane_r) begin
            unique case (wr_sel)
                sixio_pkg::SIXIO_R_WPU: wpu_r <= merge(wpu_r, w_byte_r, sixio_pkg::MASK_FULL);
                sixio_pkg::SIXIO_R_ODC: odc_r <= merge(odc_r, w_byte_r, sixio_pkg::MASK_NO3);
                sixio_pkg::SIXIO_R_SLR: slr_r <= merge(slr_r, w_byte_r, sixio_pkg::MASK_FULL);
                sixio_pkg::SIXIO_R_LVL: lvl_r <= merge(lvl_r, w_byte_r, sixio_pkg::MASK_FULL);
                default: ;
            endcase
        end
    end

    // Read channel: one read in flight; data is registered with the response.
    assign s_axi_arready = !rvalid_r;
    assign rd_sel = decode(s_axi_araddr);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rresp_r <= sixio_pkg::RESP_OKAY;
            rdata_r <= 32'h0000_0000;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_r <= 1'b1;
            rresp_r <= sixio_pkg::RESP_OKAY;
            rdata_r <= 32'h0000_0000;
            unique case (rd_sel)
                sixio_pkg::SIXIO_R_PIN: rdata_r[W-1:0] <= pin_read;
                sixio_pkg::SIXIO_R_LAT: rdata_r[W-1:0] <= lat_r;
                sixio_pkg::SIXIO_R_DIR: rdata_r[W-1:0] <= dir_r | sixio_pkg::DIR_FIXED_ONES;
                sixio_pkg::SIXIO_R_ANA: rdata_r[W-1:0] <= ana_r;
                sixio_pkg::SIXIO_R_WPU: rdata_r[W-1:0] <= wpu_r;
                sixio_pkg::SIXIO_R_ODC: rdata_r[W-1:0] <= odc_r;
                sixio_pkg::SIXIO_R_SLR: rdata_r[W-1:0] <= slr_r;
                sixio_pkg::SIXIO_R_LVL: rdata_r[W-1:0] <= lvl_r;
                default: rresp_r <= sixio_pkg::RESP_SLVERR;
            endcase
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp = rresp_r;
    assign s_axi_rdata = rdata_r;

    assign cfg.dir = dir_r;
    assign cfg.lat = lat_r;
    assign cfg.ana = ana_r;
    assign cfg.wpu = wpu_r;
    assign cfg.odc = odc_r;
    assign cfg.slr = slr_r;
    assign cfg.lvl = lvl_r;

    sixio_pad_mux u_pad (
        .cfg(cfg.pad),
        .periph_sel(periph_sel),
        .periph_out(periph_out),
        .i2c_sel(i2c_sel),
        .aout_en(aout_en),
        .pin_o(pin_o),
        .pin_oe_n(pin_oe_n),
        .pull_up_en(pull_up_en),
        .slew_limit(slew_limit),
        .thresh_cmos(thresh_cmos),
        .in_buf_en(in_buf_en)
    );

    chk_input_only: assert property (
        @(posedge aclk) disable iff (!aresetn)
        pin_oe_n[sixio_pkg::IN_ONLY_BIT] && dir_r[sixio_pkg::IN_ONLY_BIT])
        else $error("input-only pin driven or its direction bit cleared");

    chk_dir_off: assert property (
        @(posedge aclk) disable iff (!aresetn)
        ((dir_r | aout_en) & ~pin_oe_n) == '0)
        else $error("driver enabled on an input or analog-output pin");

    chk_dir_drive: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (dir_r[0] == 1'b0 && aout_en[0] == 1'b0 && odc_r[0] == 1'b0 && i2c_sel[0] == 1'b0
            && periph_sel[0] == 1'b0) |-> (!pin_oe_n[0] && pin_o[0] == lat_r[0]))
        else $error("pin 0 output does not carry the latch");

    chk_analog_read: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (s_axi_arvalid && s_axi_arready && s_axi_araddr == sixio_pkg::OFS_PIN)
        |=> (s_axi_rdata[W-1:0] & $past(ana_r)) == '0 && s_axi_rdata[31:W] == '0)
        else $error("analog pin read back as nonzero");

    chk_latch_read: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (s_axi_arvalid && s_axi_arready && s_axi_araddr == sixio_pkg::OFS_LAT)
        |=> s_axi_rvalid && s_axi_rdata[W-1:0] == $past(lat_r))
        else $error("latch read does not return latch contents");

    chk_latch_write: assert property (
        @(posedge aclk) disable iff (!aresetn)
        wr_hit_lat |=> lat_r == ($past(w_byte_r[W-1:0]) & sixio_pkg::MASK_NO3))
        else $error("latch does not hold the last written value");

    chk_write_resp: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready)
        |=> ##1 s_axi_bvalid)
        else $error("write response not raised two cycles after both channels");

    chk_open_drain: assert property (
        @(posedge aclk) disable iff (!aresetn)
        ((odc_r | i2c_sel) & ~pin_oe_n & pin_o) == '0)
        else $error("open-drain pin sourced current");

    chk_pull_up: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (pull_up_en & ~(dir_r | odc_r | i2c_sel)) == '0)
        else $error("pull-up on a push-pull output");

    chk_analog_buf: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (in_buf_en & ana_r) == '0)
        else $error("input buffer on with analog select set");

    chk_ana_reset: assert property (
        @(posedge aclk)
        !aresetn |=> ana_r == sixio_pkg::RST_ANA && lat_r == sixio_pkg::RST_LAT)
        else $error("analog select or latch not at reset value");

    chk_bresp_hold: assert property (
        @(posedge aclk) disable iff (!aresetn)
        (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before taken");

endmodule // sixio_port

// *** tb/sixio_board.sv ***
`timescale 1ns/10ps
module sixio_board (
    input wire logic clk,
    input wire logic [5:0] pin_o,
    input wire logic [5:0] pin_oe_n,
    input wire logic [5:0] pull_up_en,
    input wire logic [5:0] ext_en,
    input wire logic [5:0] ext_val,
    output logic [5:0] pin_i
);
    // A line that nobody drives toggles, so a floating pin never reads as a stable level.
    logic [5:0] float_r = 6'h15;
    always_ff @(posedge clk) begin
        float_r <= ~float_r;
    end
    always_comb begin
        for (int k = 0; k < 6; k++) begin
            if (!pin_oe_n[k]) pin_i[k] = pin_o[k];
            else if (ext_en[k]) pin_i[k] = ext_val[k];
            else if (pull_up_en[k]) pin_i[k] = 1'b1;
            else pin_i[k] = float_r[k];
        end
    end
endmodule // sixio_board

// *** tb/test_six_bit_io_port_control.sv ***
`timescale 1ns/10ps
module test_six_bit_io_port_control;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [5:0] pin_i, pin_o, oe_n, pu, slew, thr, ibuf, plevel;
    logic [5:0] psel = 6'h00, pout = 6'h00, i2c = 6'h00, aout = 6'h00;
    logic [5:0] ext_en = 6'h00, ext_val = 6'h00;
    int errors = 0;
    int checked = 0;
    int cyc = 0;
    localparam int OBS_OE = 0;
    localparam int OBS_OUT = 1;
    localparam int OBS_PU = 2;
    localparam int OBS_SLEW = 3;
    localparam int OBS_THR = 4;
    localparam int OBS_IBUF = 5;
    localparam int OBS_LVL = 6;

    sixio_port sixio_port_i (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .pin_i(pin_i), .pin_o(pin_o), .pin_oe_n(oe_n), .pull_up_en(pu), .slew_limit(slew),
        .thresh_cmos(thr), .in_buf_en(ibuf), .pin_level(plevel), .periph_sel(psel),
        .periph_out(pout), .i2c_sel(i2c), .aout_en(aout));
    sixio_board sixio_board_i (.clk(aclk), .pin_o(pin_o), .pin_oe_n(oe_n), .pull_up_en(pu),
        .ext_en(ext_en), .ext_val(ext_val), .pin_i(pin_i));

    always #5 aclk = ~aclk;

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            errors++;
            $display("[ERR] %0t run did not complete", $time);
            give_verdict();
        end
    end

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t word %h expected %h", $time, got, exp);
        end
    endtask

    // The pad signal is picked only after the falling edge, so a value passed in at the call
    // cannot be stale; the task then returns on a rising edge, where stimulus may change.
    task automatic chk_pins(input int sel, input logic [5:0] m, input logic [5:0] exp);
        logic [5:0] got;
        @(negedge aclk);
        case (sel)
            OBS_OE: got = oe_n;
            OBS_OUT: got = pin_o;
            OBS_PU: got = pu;
            OBS_SLEW: got = slew;
            OBS_THR: got = thr;
            OBS_IBUF: got = ibuf;
            default: got = plevel;
        endcase
        got = got & m;
        checked++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t pins %h expected %h", $time, got, exp);
        end
        @(posedge aclk);
    endtask

    // A nonzero bw keeps bready low for that many cycles, so the response has to wait.
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = 2'h0,
        input logic [3:0] s = 4'h1, input int bw = 0);
        logic ah, wh, bd;
        logic [1:0] rp;
        int n;
        @(posedge aclk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= {24'h0, d};
        wstrb <= s;
        wvalid <= 1'b1;
        bready <= (bw == 0);
        bd = 1'b0;
        n = 0;
        while (!bd) begin
            @(negedge aclk);
            ah = awvalid && awready;
            wh = wvalid && wready;
            bd = (bvalid === 1'b1) && bready;
            rp = bresp;
            @(posedge aclk);
            n++;
            if (ah) awvalid <= 1'b0;
            if (wh) wvalid <= 1'b0;
            if (bd) bready <= 1'b0;
            else if (n >= bw) bready <= 1'b1;
        end
        chk_word({30'h0, rp}, {30'h0, er});
    endtask

    task automatic rd(input logic [7:0] a, input logic [5:0] e, input logic [1:0] er = 2'h0);
        logic ah, rd_done;
        logic [31:0] v;
        logic [1:0] rp;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        rd_done = 1'b0;
        while (!rd_done) begin
            @(negedge aclk);
            ah = arvalid && arready;
            rd_done = (rvalid === 1'b1);
            v = rdata;
            rp = rresp;
            @(posedge aclk);
            if (ah) arvalid <= 1'b0;
            if (rd_done) rready <= 1'b0;
        end
        chk_word(v, {26'h0, e});
        chk_word({30'h0, rp}, {30'h0, er});
    endtask

    task automatic t_reset;
        rd(sixio_pkg::OFS_DIR, 6'h3f);
        rd(sixio_pkg::OFS_LAT, 6'h00);
        rd(sixio_pkg::OFS_ANA, 6'h37);
        rd(sixio_pkg::OFS_WPU, 6'h00);
        rd(sixio_pkg::OFS_ODC, 6'h00);
        chk_pins(OBS_OE, 6'h3f, 6'h3f);
        chk_pins(OBS_IBUF, 6'h3f, 6'h08);
    endtask

    task automatic t_dir_latch;
        wr(sixio_pkg::OFS_DIR, 8'h00);
        rd(sixio_pkg::OFS_DIR, 6'h08);
        wr(sixio_pkg::OFS_DIR, 8'hff);
        rd(sixio_pkg::OFS_DIR, 6'h3f);
        wr(sixio_pkg::OFS_PIN, 8'hff);
        rd(sixio_pkg::OFS_LAT, 6'h37);
        wr(sixio_pkg::OFS_LAT, 8'h15);
        rd(sixio_pkg::OFS_LAT, 6'h15);
        wr(sixio_pkg::OFS_PIN, 8'h22);
        rd(sixio_pkg::OFS_LAT, 6'h22);
        wr(sixio_pkg::OFS_LAT, 8'h3f, 2'h0, 4'h0);
        rd(sixio_pkg::OFS_LAT, 6'h22);
    endtask

    task automatic t_pins;
        ext_en <= 6'h08;
        ext_val <= 6'h08;
        wr(sixio_pkg::OFS_ANA, 8'h00);
        wr(sixio_pkg::OFS_DIR, 8'h00);
        chk_pins(OBS_OE, 6'h3f, 6'h08);
        chk_pins(OBS_OUT, 6'h37, 6'h22);
        repeat (3) @(posedge aclk);
        rd(sixio_pkg::OFS_PIN, 6'h2a);
        wr(sixio_pkg::OFS_DIR, 8'h3f);
        ext_en <= 6'h3f;
        ext_val <= 6'h2d;
        repeat (4) @(posedge aclk);
        rd(sixio_pkg::OFS_PIN, 6'h2d);
        wr(sixio_pkg::OFS_ANA, 8'h05);
        rd(sixio_pkg::OFS_PIN, 6'h28);
        chk_pins(OBS_LVL, 6'h3f, 6'h28);
        chk_pins(OBS_IBUF, 6'h3f, 6'h3a);
        rd(sixio_pkg::OFS_LAT, 6'h22);
        ext_en <= 6'h3e;
        wr(sixio_pkg::OFS_DIR, 8'h3e);
        chk_pins(OBS_OE, 6'h3f, 6'h3e);
        wr(sixio_pkg::OFS_DIR, 8'h3f);
        wr(sixio_pkg::OFS_ANA, 8'h00);
    endtask

    task automatic t_drive;
        ext_en <= 6'h00;
        wr(sixio_pkg::OFS_WPU, 8'h03);
        wr(sixio_pkg::OFS_ODC, 8'h01);
        wr(sixio_pkg::OFS_LAT, 8'h03);
        wr(sixio_pkg::OFS_DIR, 8'h3c);
        chk_pins(OBS_OE, 6'h3f, 6'h3d);
        chk_pins(OBS_PU, 6'h3f, 6'h01);
        wr(sixio_pkg::OFS_LAT, 8'h02);
        chk_pins(OBS_OE, 6'h3f, 6'h3c);
        chk_pins(OBS_OUT, 6'h03, 6'h02);
        chk_pins(OBS_PU, 6'h3f, 6'h00);
        i2c <= 6'h02;
        aout <= 6'h01;
        chk_pins(OBS_OE, 6'h3f, 6'h3f);
        i2c <= 6'h00;
        aout <= 6'h00;
        psel <= 6'h02;
        ext_en <= 6'h3c;
        ext_val <= 6'h3c;
        chk_pins(OBS_OUT, 6'h03, 6'h00);
        repeat (3) @(posedge aclk);
        rd(sixio_pkg::OFS_PIN, 6'h3c);
        psel <= 6'h00;
        wr(sixio_pkg::OFS_ODC, 8'h00);
        wr(sixio_pkg::OFS_DIR, 8'h3f);
    endtask

    task automatic t_misc;
        wr(sixio_pkg::OFS_SLR, 8'h15);
        chk_pins(OBS_SLEW, 6'h3f, 6'h15);
        rd(sixio_pkg::OFS_SLR, 6'h15);
        wr(sixio_pkg::OFS_LVL, 8'h2a);
        chk_pins(OBS_THR, 6'h3f, 6'h2a);
        rd(sixio_pkg::OFS_LVL, 6'h2a);
        wr(8'h40, 8'h01, sixio_pkg::RESP_SLVERR, 4'h1, 3);
        rd(8'h40, 6'h00, sixio_pkg::RESP_SLVERR);
    endtask

    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_dir_latch();
        t_pins();
        t_drive();
        t_misc();
        give_verdict();
    end
endmodule // test_six_bit_io_port_control
